// ==== dv/brake_asserts.sv ====
// brake sequencer checker, bound from tb
// sees top ports only, one clock
`timescale 1ns/1ps
`default_nettype none
// ==========
// braking checks
module brake_asserts (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [11:0] link_voltage,
   input wire logic        flying_restart_active,
   input wire logic        coast_stop_req,
   input wire logic        ramp_down_req,
   input wire logic [15:0] dc_current_req,
   input wire logic        dc_brake_active,
   input wire logic        compound_active_flag,
   input wire logic        brake_fault
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   a_idle_no_cur:
      assert property (!dc_brake_active && !compound_active_flag
         |-> dc_current_req == 16'h0000) else $error("stray current");
   a_coast_no_cur:
      assert property (coast_stop_req |-> dc_current_req == 16'h0000)
         else $error("coast current");
   a_deexc_first:
      assert property ($rose(dc_brake_active) |-> coast_stop_req)
         else $error("no coast first");
   a_comp_dc_off:
      assert property ($rose(dc_brake_active) |=> !compound_active_flag)
         else $error("comp in dc");
   a_comp_flying:
      assert property (flying_restart_active |=> !compound_active_flag)
         else $error("comp in restart");
   a_comp_link:
      assert property (link_voltage == 12'h000 |=> !compound_active_flag)
         else $error("comp low link");
   a_ramp_no_dc:
      assert property (ramp_down_req |-> !dc_brake_active)
         else $error("dc in ramp");
   a_trip_source:
      assert property ($rose(brake_fault) |-> $past(dc_brake_active))
         else $error("stray trip");
   c_inject: cover property (dc_brake_active && !coast_stop_req);
   c_comp: cover property (compound_active_flag);
   c_ramp: cover property (ramp_down_req);
endmodule
`default_nettype wire

// ==== dv/power_stage.sv ====
// power stage and motor model: shaft speed
// assumes the sequencer's clock and reset
`timescale 1ns/1ps
`default_nettype none
// ==========
// motor speed
module power_stage (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        ramp_down_req,
   input  wire logic        ld,
   input  wire logic [17:0] ld_val,
   output logic      [17:0] speed_actual
);
   // steep slope: a stop ramps in a few dozen cycles
   always_ff @(posedge ref_clk) begin
      if (!rstn)
         speed_actual <= 18'h0_0000;
      else if (ld)
         speed_actual <= ld_val;
      else if (ramp_down_req && speed_actual >= 18'h0_00FA)
         speed_actual <= speed_actual - 18'h0_00FA;
   end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the brake sequencer
// assumes brake_cfg.svh on the include path; 1 ms is 4 cycles
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"
// ==========
// bench
module tb;
   logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        ramp_stop_cmd, quick_stop_cmd, digital_input_three, ld;
   logic        fault_strobe, flying_restart_active, overcurrent_in;
   logic [15:0] fault_code, dc_current_req;
   logic [11:0] link_voltage;
   logic [17:0] speed_actual, ld_val;
   logic        coast_stop_req, ramp_down_req, dc_brake_active;
   logic        compound_active_flag, brake_fault;
   int          err_total, checks_done, i;
   dc_and_compound_brake_sequencer #(.TICK_CYCLES(4)) u_dut (.*);
   power_stage u_ps (.*);
   task cyc(input int c);
      repeat (c) @(posedge ref_clk);
   endtask
   task chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      chk("err", {31'h0, a > 8'h38}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0000_0000);
      chk(n, e, rd);
   endtask
   task t_regs;
      rdc(`A_CTRL, 32'h0000_00C0, "ctrl");
      rdc(`A_CURRENT, 32'h0000_0000, "cur");
      rdc(`A_DURATION, 32'h0000_03E8, "dur");
      rdc(`A_START_SPD, 32'h0003_3450, "spd");
      rdc(`A_FREACT, 32'h0000_0000, "react");
      rdc(8'h3C, 32'h0000_0000, "hole");
      wr(`A_TAU, 32'h0000_0007);
      wr(`A_CALC, 32'h0000_0003);
      rdc(`A_DEEXC, 32'h0000_000E, "deexc");
      $display("test regs done");
   endtask
   task t_speed;
      wr(`A_DEEXC, 32'h0000_0002);
      wr(`A_DURATION, 32'h0000_0003);
      wr(`A_CURRENT, 32'h0000_0055);
      wr(`A_START_SPD, 32'h0000_03E8);
      wr(`A_CTRL, 32'h0000_00DE);
      rdc(`A_STATUS, 32'h0000_0801, "mirror");
      ld_val <= 18'h0_01F4;
      ld <= 1'b1;
      cyc(20);
      chk("unarmed", 32'h0, 32'(dc_brake_active));
      ld_val <= 18'h0_07D0;
      cyc(3);
      ld_val <= 18'h0_01F4;
      for (i = 0; i < 9 && dc_brake_active !== 1'b1; i++) cyc(1);
      chk("coast", 32'h1, 32'(coast_stop_req));
      for (i = 0; i < 30 && coast_stop_req; i++) cyc(1);
      chk("inject", 32'h55, 32'(dc_current_req));
      for (i = 0; i < 30 && dc_brake_active; i++) cyc(1);
      chk("span", 32'h1, 32'(i > 10 && i < 16));
      chk("resume", 32'h0, 32'(dc_current_req));
      ld_val <= 18'h0_07D0;
      cyc(3);
      ld_val <= 18'h0_01F4;
      cyc(4);
      wr(`A_CTRL, 32'h0000_00CE);
      cyc(4);
      chk("abort", 32'h0, 32'(dc_brake_active));
      $display("test speed done");
   endtask
   task t_cmd;
      wr(`A_CTRL, 32'h0000_00E4);
      digital_input_three <= 1'b1;
      for (i = 0; i < 9 && dc_brake_active !== 1'b1; i++) cyc(1);
      chk("cmd", 32'h1, 32'(dc_brake_active));
      apb(1'b0, `A_STATUS, 32'h0000_0000);
      chk("di", 32'h1, 32'(rd[11]));
      overcurrent_in <= 1'b1;
      for (i = 0; i < 9 && brake_fault !== 1'b1; i++) cyc(1);
      chk("trip", 32'h1, 32'(brake_fault & coast_stop_req));
      overcurrent_in <= 1'b0;
      digital_input_three <= 1'b0;
      cyc(6);
      wr(`A_STATUS, 32'h0000_0100);
      // trip clears at the write edge, the state leaves a cycle later
      cyc(2);
      chk("clear", 32'h0, 32'(brake_fault | coast_stop_req));
      $display("test cmd done");
   endtask
   task t_stop;
      ld_val <= 18'h0_1388;
      for (int k = 0; k < 2; k++) begin
         ld <= 1'b1;
         wr(`A_CTRL, 32'h0000_00C5);
         ld <= 1'b0;
         {quick_stop_cmd, ramp_stop_cmd} <= k ? 2'b10 : 2'b01;
         for (i = 0; i < 9 && !ramp_down_req; i++) cyc(1);
         chk("ramp", 32'h1, 32'(ramp_down_req));
         for (i = 0; i < 90 && (!coast_stop_req || dc_brake_active); i++)
            cyc(1);
         chk("off", 32'h1, 32'(speed_actual < 18'h0_03E8));
         {quick_stop_cmd, ramp_stop_cmd} <= 2'b00;
         cyc(3);
      end
      ld <= 1'b1;
      wr(`A_CTRL, 32'h0000_0085);
      ramp_stop_cmd <= 1'b1;
      cyc(9);
      chk("motor", 32'h0, 32'(ramp_down_req));
      ramp_stop_cmd <= 1'b0;
      $display("test stop done");
   endtask
   task t_fault;
      wr(`A_FIDX, 32'h0000_0005);
      wr(`A_FNUM, 32'h0000_1EB4);
      wr(`A_FREACT, 32'h0000_0006);
      rdc(`A_FNUM, 32'h0000_1EB4, "fnum");
      wr(`A_CTRL, 32'h0000_00C4);
      fault_code <= 16'h1EB4;
      fault_strobe <= 1'b1;
      ld <= 1'b0;
      cyc(1);
      fault_strobe <= 1'b0;
      for (i = 0; i < 15 && !ramp_down_req; i++) cyc(1);
      chk("fault", 32'h1, 32'(ramp_down_req));
      for (i = 0; i < 40 && !dc_brake_active; i++) cyc(1);
      chk("fbrake", 32'h1, 32'(dc_brake_active));
      cyc(30);
      $display("test fault done");
   endtask
   task t_comp;
      wr(`A_RATED, 32'h0000_0064);
      wr(`A_COMP_PCT, 32'h0000_012C);
      rdc(`A_COMP_PCT, 32'h0000_00FA, "pct");
      wr(`A_LINK_THR, 32'h0000_0100);
      link_voltage <= 12'h200;
      cyc(3);
      chk("ccur", 32'h0000_00FA, 32'(dc_current_req));
      rdc(`A_COMP_STAT, 32'h0000_0001, "cstat");
      flying_restart_active <= 1'b1;
      cyc(2);
      chk("restart", 32'h0, 32'(compound_active_flag));
      flying_restart_active <= 1'b0;
      wr(`A_CTRL, 32'h0000_0044);
      cyc(2);
      chk("vector", 32'h0, 32'(compound_active_flag));
      $display("test comp done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      {rstn, psel, penable, pwrite, ramp_stop_cmd, quick_stop_cmd} = '0;
      {digital_input_three, fault_strobe, flying_restart_active} = '0;
      {overcurrent_in, ld, paddr, pwdata, fault_code} = '0;
      {link_voltage, ld_val} = '0;
      err_total = 0;
      checks_done = 0;
      cyc(20);
      rstn <= 1'b1;
      t_regs;
      t_speed;
      t_cmd;
      t_stop;
      t_fault;
      t_comp;
      close_out;
   end
   // the tests need well under 2000 cycles
   initial begin
      cyc(6000);
      err_total++;
      close_out;
   end
endmodule
bind dc_and_compound_brake_sequencer brake_asserts u_chk (.*);
`default_nettype wire

// ==== logic/brake_cfg.svh ====
// brake sequencer constants: offsets, fields, resets, timing
// assumes a 10 MHz clock and a 32-bit apb port
`ifndef BRAKE_CFG_SVH
`define BRAKE_CFG_SVH

// ==========================================================
// widths
`define APB_AW       8
`define SPD_W        18
`define VOLT_W       12
`define TBL_AW       3
`define TBL_DEPTH    8
`define REACT_W      4
`define PRE_W        14

// ==========================================================
// register byte offsets
`define A_CTRL       8'h00
`define A_CURRENT    8'h04
`define A_DURATION   8'h08
`define A_START_SPD  8'h0C
`define A_DEEXC      8'h10
`define A_CALC       8'h14
`define A_TAU        8'h18
`define A_LINK_THR   8'h1C
`define A_COMP_PCT   8'h20
`define A_RATED      8'h24
`define A_STATUS     8'h28
`define A_COMP_STAT  8'h2C
`define A_FIDX       8'h30
`define A_FNUM       8'h34
`define A_FREACT     8'h38

// ==========================================================
// fields
`define C_MODE_LSB   0
`define C_MODE_MSB   3
`define C_ACT_DIRECT 4
`define C_ACT_SEL    5
`define C_INDUCTION  6
`define C_VF         7
`define S_ST_MSB     5
`define S_TRIP       8
`define S_ARMED      9
`define S_MIRROR     11
`define CS_ACTIVE    0

// ==========================================================
// codes and reset values
`define MODE_OFF     4'h0
`define MODE_CMD     4'h4
`define MODE_STOP    4'h5
`define MODE_SPEED   4'hE
`define REACT_DC     4'h6
`define CALC_A       8'h01
`define CALC_B       8'h03
`define COMP_PCT_MAX 8'hFA
`define PCT_FULL     24'h00_0064
`define CTRL_RST     8'hC0
`define CUR_RST      16'h0000
`define DUR_RST      16'h03E8
`define SPD_RST      18'h3_3450
`define DEEXC_RST    16'h0064
`define TAU_RST      16'h0032
`define THR_RST      12'hFFF
`define RATED_RST    16'h0000
`define SCAN_END     4'h8
`define CNT_ONE      16'h0001
`define PRE_ONE      14'h0001
`define SCAN_ONE     4'h1

// ==========================================================
// timing: 1 ms tick derived from the clock period
`define CLK_PERIOD_NS 100
`define TICK_NS       1000000
`define TICK_CYCLES   (`TICK_NS / `CLK_PERIOD_NS)

`endif

// ==== logic/brake_if.sv ====
// carriers between the sequencer and its timer and fault table
// assumes brake_cfg.svh is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

interface timer_if;
   logic        start;
   logic [15:0] load;
   logic        done;
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface

interface table_if;
   logic [`TBL_AW-1:0]  addr;
   logic                we_num;
   logic                we_react;
   logic [15:0]         wnum;
   logic [`REACT_W-1:0] wreact;
   logic [15:0]         rnum;
   logic [`REACT_W-1:0] rreact;
   modport ctl (output addr, output we_num, output we_react,
                output wnum, output wreact, input rnum, input rreact);
   modport mem (input addr, input we_num, input we_react,
                input wnum, input wreact, output rnum, output rreact);
endinterface

`default_nettype wire

// ==== logic/brake_pkg.sv ====
// types shared by the brake sequencer and its helpers
// assumes brake_cfg.svh is on the include path
`default_nettype none
`include "brake_cfg.svh"

package brake_pkg;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b00_0001,
      ST_RAMP   = 6'b00_0010,
      ST_DEEXC  = 6'b00_0100,
      ST_INJECT = 6'b00_1000,
      ST_COAST  = 6'b01_0000,
      ST_TRIP   = 6'b10_0000
   } brake_state_t;

   typedef enum logic [1:0] {
      ORG_SPEED = 2'h0,
      ORG_CMD   = 2'h1,
      ORG_STOP  = 2'h2,
      ORG_FAULT = 2'h3
   } origin_t;

   typedef struct packed {
      logic [`PRE_W-1:0] pre;
      logic [15:0]       cnt;
      logic              run;
      logic              done;
   } timer_state_t;

   typedef struct packed {
      logic [`TBL_DEPTH-1:0][15:0]         num;
      logic [`TBL_DEPTH-1:0][`REACT_W-1:0] react;
      logic [15:0]                         rnum;
      logic [`REACT_W-1:0]                 rreact;
   } table_state_t;

   typedef struct packed {
      logic [7:0]         ctrl;
      logic [15:0]        cur;
      logic [15:0]        dur;
      logic [`SPD_W-1:0]  spd;
      logic [15:0]        deexc;
      logic [15:0]        tau;
      logic [`VOLT_W-1:0] thr;
      logic [7:0]         pct;
      logic [15:0]        rated;
      logic [`TBL_AW-1:0] fidx;
      logic [2:0]         di_sync;
      logic [2:0]         oc_sync;
      logic               di_lvl;
      logic               oc_lvl;
      brake_state_t       st;
      origin_t            org;
      logic               armed;
      logic               trip;
      logic               scan;
      logic [3:0]         scan_cnt;
      logic [15:0]        fcode;
      logic               tbl_ok;
      logic               tw_num;
      logic               tw_react;
      logic [15:0]        twd;
      logic               start;
      logic [15:0]        tload;
      logic               coast;
      logic               ramp;
      logic               dc_act;
      logic               comp;
      logic [15:0]        cur_out;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
   } main_state_t;

endpackage

`default_nettype wire

// ==== logic/brake_timer.sv ====
// millisecond down counter with its own prescaler
// assumes start is a one-cycle pulse; restarting drops any pending run
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

module brake_timer
   import brake_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   timer_if.tmr     bus
);

   timer_state_t q;
   timer_state_t n;

   always_comb begin
      n = q;
      n.done = 1'b0;
      if (bus.start) begin
         n.pre = '0;
         n.cnt = bus.load;
         n.run = 1'b1;
      end else if (q.run) begin
         if (q.cnt == '0) begin
            n.run  = 1'b0;
            n.done = 1'b1;
         end else if (q.pre == `PRE_W'(TICK_CYCLES - 1)) begin
            n.pre = '0;
            n.cnt = q.cnt - `CNT_ONE;
         end else begin
            n.pre = q.pre + `PRE_ONE;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.done = q.done;

endmodule

`default_nettype wire

// ==== logic/dc_and_compound_brake_sequencer.sv ====
// dc and compound brake sequencer, apb registers
// assumes speed, stop, fault and link inputs come from logic on
// ref_clk; the digital input and overcurrent pins are asynchronous
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

module dc_and_compound_brake_sequencer
   import brake_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [`APB_AW-1:0]  paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [`SPD_W-1:0]   speed_actual,
   input  wire logic                ramp_stop_cmd,
   input  wire logic                quick_stop_cmd,
   input  wire logic                digital_input_three,
   input  wire logic                fault_strobe,
   input  wire logic [15:0]         fault_code,
   input  wire logic [`VOLT_W-1:0]  link_voltage,
   input  wire logic                flying_restart_active,
   input  wire logic                overcurrent_in,
   output logic                     coast_stop_req,
   output logic                     ramp_down_req,
   output logic      [15:0]         dc_current_req,
   output logic                     dc_brake_active,
   output logic                     compound_active_flag,
   output logic                     brake_fault
);

   // =======================================================
   // helpers
   function automatic logic [15:0] pct_of(input logic [7:0]  p,
                                          input logic [15:0] r);
      logic [23:0] prod;
      prod = 24'(p) * 24'(r);
      return 16'(prod / `PCT_FULL);
   endfunction

   function automatic logic timed_phase(input brake_state_t s);
      return (s == ST_DEEXC) || (s == ST_INJECT);
   endfunction

   // =======================================================
   // state and submodules
   main_state_t q;
   main_state_t n;

   timer_if tmr_bus ();
   table_if tbl_bus ();

   brake_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .bus     (tmr_bus.tmr)
   );

   fault_table u_table (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .bus     (tbl_bus.mem)
   );

   assign tmr_bus.start = q.start;
   assign tmr_bus.load  = q.tload;

   // a pending table write owns the address over the scanner
   assign tbl_bus.addr = (q.scan && !(q.tw_num || q.tw_react)) ?
                         q.scan_cnt[`TBL_AW-1:0] : q.fidx;
   assign tbl_bus.we_num   = q.tw_num;
   assign tbl_bus.we_react = q.tw_react;
   assign tbl_bus.wnum     = q.twd;
   assign tbl_bus.wreact   = q.twd[`REACT_W-1:0];

   // =======================================================
   // combinational scratch
   logic              act;
   logic [3:0]        mode;
   logic              below;
   logic              above;
   logic              stop;
   logic              tdone;
   logic              access;
   logic              tbl_acc;
   logic              match;
   logic              comp_ok;
   logic [31:0]       status;

   always_comb begin
      n = q;
      n.start    = 1'b0;
      n.tw_num   = 1'b0;
      n.tw_react = 1'b0;

      // pins: three flops, last two must agree
      n.di_sync = {q.di_sync[1:0], digital_input_three};
      n.oc_sync = {q.oc_sync[1:0], overcurrent_in};
      if (q.di_sync[2] == q.di_sync[1]) begin
         n.di_lvl = q.di_sync[2];
      end
      if (q.oc_sync[2] == q.oc_sync[1]) begin
         n.oc_lvl = q.oc_sync[2];
      end

      act = q.ctrl[`C_ACT_SEL] ? q.di_lvl : q.ctrl[`C_ACT_DIRECT];
      // a non-induction motor keeps the setting but never dc brakes
      mode = q.ctrl[`C_INDUCTION] ?
             q.ctrl[`C_MODE_MSB:`C_MODE_LSB] : `MODE_OFF;
      below  = speed_actual < q.spd;
      above  = speed_actual > q.spd;
      stop   = ramp_stop_cmd | quick_stop_cmd;
      tdone  = tmr_bus.done & ~q.start;
      access = psel & penable;
      tbl_acc = (paddr == `A_FNUM) || (paddr == `A_FREACT);

      status = '0;
      status[`S_ST_MSB:0] = q.st;
      status[`S_TRIP]     = q.trip;
      status[`S_ARMED]    = q.armed;
      status[`S_MIRROR]   = act;

      // ====================================================
      // apb: answer in access cycle two, table registers wait while a fault scan runs,
      // write when pready is seen
      n.pready = 1'b0;
      if (access && !q.pready &&
          !(tbl_acc && (q.scan || !q.tbl_ok))) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         n.prdata  = '0;
         case (paddr)
            `A_CTRL:      n.prdata = 32'(q.ctrl);
            `A_CURRENT:   n.prdata = 32'(q.cur);
            `A_DURATION:  n.prdata = 32'(q.dur);
            `A_START_SPD: n.prdata = 32'(q.spd);
            `A_DEEXC:     n.prdata = 32'(q.deexc);
            `A_CALC:      n.prdata = '0;
            `A_TAU:       n.prdata = 32'(q.tau);
            `A_LINK_THR:  n.prdata = 32'(q.thr);
            `A_COMP_PCT:  n.prdata = 32'(q.pct);
            `A_RATED:     n.prdata = 32'(q.rated);
            `A_STATUS:    n.prdata = status;
            `A_COMP_STAT: n.prdata[`CS_ACTIVE] = q.comp;
            `A_FIDX:      n.prdata = 32'(q.fidx);
            `A_FNUM:      n.prdata = 32'(tbl_bus.rnum);
            `A_FREACT:    n.prdata = 32'(tbl_bus.rreact);
            default:      n.pslverr = 1'b1;
         endcase
      end
      if (access && q.pready && pwrite && !q.pslverr) begin
         case (paddr)
            `A_CTRL:      n.ctrl  = pwdata[7:0];
            `A_CURRENT:   n.cur   = pwdata[15:0];
            `A_DURATION:  n.dur   = pwdata[15:0];
            `A_START_SPD: n.spd   = pwdata[`SPD_W-1:0];
            `A_DEEXC:     n.deexc = pwdata[15:0];
            `A_CALC: begin
               // de-excitation is twice the rotor time constant
               if (pwdata[7:0] == `CALC_A || pwdata[7:0] == `CALC_B) begin
                  n.deexc = {q.tau[14:0], 1'b0};
               end
            end
            `A_TAU:       n.tau   = pwdata[15:0];
            `A_LINK_THR:  n.thr   = pwdata[`VOLT_W-1:0];
            `A_COMP_PCT: begin
               n.pct = (pwdata[7:0] > `COMP_PCT_MAX || |pwdata[31:8]) ?
                       `COMP_PCT_MAX : pwdata[7:0];
            end
            `A_RATED:     n.rated = pwdata[15:0];
            `A_STATUS: begin
               if (pwdata[`S_TRIP]) begin
                  n.trip = 1'b0;
               end
            end
            `A_FIDX:      n.fidx  = pwdata[`TBL_AW-1:0];
            `A_FNUM: begin
               n.tw_num = 1'b1;
               n.twd    = pwdata[15:0];
            end
            `A_FREACT: begin
               n.tw_react = 1'b1;
               n.twd      = pwdata[15:0];
            end
            default: n.twd = q.twd;
         endcase
      end
      n.tbl_ok = ~q.scan;

      // ====================================================
      // fault lookup, read data one entry behind
      match = 1'b0;
      if (q.scan) begin
         n.scan_cnt = q.scan_cnt + `SCAN_ONE;
         if (q.scan_cnt != '0 && tbl_bus.rnum == q.fcode &&
             tbl_bus.rreact == `REACT_DC) begin
            match = 1'b1;
         end
         if (match || q.scan_cnt == `SCAN_END) begin
            n.scan = 1'b0;
         end
      end else if (fault_strobe && q.st == ST_IDLE &&
                   mode != `MODE_OFF) begin
         n.scan     = 1'b1;
         n.scan_cnt = '0;
         n.fcode    = fault_code;
      end

      if (above) begin
         n.armed = 1'b1;
      end

      // ====================================================
      // braking sequence; triggers only count while idle
      case (q.st)
         ST_IDLE: begin
            if (mode == `MODE_SPEED && q.armed && below) begin
               n.st    = ST_DEEXC;
               n.org   = ORG_SPEED;
               n.armed = 1'b0;
            end else if (mode == `MODE_CMD && act) begin
               n.st  = ST_DEEXC;
               n.org = ORG_CMD;
            end else if (mode == `MODE_STOP && stop) begin
               n.st  = ST_RAMP;
               n.org = ORG_STOP;
            end else if (match) begin
               n.st  = ST_RAMP;
               n.org = ORG_FAULT;
            end
            if (n.st == ST_DEEXC) begin
               n.start = 1'b1;
               n.tload = q.deexc;
            end
         end
         ST_RAMP: begin
            if (below) begin
               n.st    = ST_DEEXC;
               n.start = 1'b1;
               n.tload = q.deexc;
               n.armed = 1'b0;
            end
         end
         ST_DEEXC: begin
            if ((q.org == ORG_CMD || q.org == ORG_SPEED) && !act) begin
               n.st = ST_IDLE;
            end else if (tdone) begin
               n.st    = ST_INJECT;
               n.start = 1'b1;
               n.tload = q.dur;
            end
         end
         ST_INJECT: begin
            if ((q.org == ORG_CMD || q.org == ORG_SPEED) && !act) begin
               n.st = ST_IDLE;
            end else if (tdone) begin
               // speed and fault sequences hand back at once
               n.st = (q.org == ORG_SPEED || q.org == ORG_FAULT) ?
                      ST_IDLE : ST_COAST;
            end
         end
         ST_COAST: begin
            // torque-free until its request drops
            if ((q.org == ORG_STOP && !stop) ||
                (q.org != ORG_STOP && !act)) begin
               n.st = ST_IDLE;
            end
         end
         ST_TRIP: begin
            if (!q.trip) begin
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      if (n.st != ST_IDLE) begin
         n.scan = 1'b0;
      end

      // set beats a same-cycle software clear
      if (q.oc_lvl && timed_phase(q.st)) begin
         n.st   = ST_TRIP;
         n.trip = 1'b1;
      end

      // ====================================================
      // outputs
      n.coast  = (n.st == ST_DEEXC) || (n.st == ST_COAST) ||
                 (n.st == ST_TRIP);
      n.ramp   = n.st == ST_RAMP;
      n.dc_act = timed_phase(n.st);
      comp_ok  = q.ctrl[`C_VF] &&
                 !flying_restart_active && !n.dc_act && !n.coast;
      n.comp   = comp_ok && (q.pct != '0) &&
                 (link_voltage > q.thr);
      if (n.st == ST_INJECT) begin
         n.cur_out = q.cur;
      end else if (n.comp) begin
         n.cur_out = pct_of(q.pct, q.rated);
      end else begin
         n.cur_out = '0;
      end
   end

   // =======================================================
   // registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q       <= '0;
         q.ctrl  <= `CTRL_RST;
         q.cur   <= `CUR_RST;
         q.dur   <= `DUR_RST;
         q.spd   <= `SPD_RST;
         q.deexc <= `DEEXC_RST;
         q.tau   <= `TAU_RST;
         q.thr   <= `THR_RST;
         q.rated <= `RATED_RST;
         q.st    <= ST_IDLE;
         q.org   <= ORG_SPEED;
      end else begin
         q <= n;
      end
   end

   assign prdata               = q.prdata;
   assign pready               = q.pready;
   assign pslverr              = q.pslverr;
   assign coast_stop_req       = q.coast;
   assign ramp_down_req        = q.ramp;
   assign dc_current_req       = q.cur_out;
   assign dc_brake_active      = q.dc_act;
   assign compound_active_flag = q.comp;
   assign brake_fault          = q.trip;

endmodule

`default_nettype wire

// ==== logic/fault_table.sv ====
// fault number and reaction tables, one registered read port
// assumes one writer at a time; read data lag the address by a cycle
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

module fault_table
   import brake_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   table_if.mem     bus
);

   table_state_t q;
   table_state_t n;

   always_comb begin
      n = q;
      if (bus.we_num) begin
         n.num[bus.addr] = bus.wnum;
      end
      if (bus.we_react) begin
         n.react[bus.addr] = bus.wreact;
      end
      n.rnum   = q.num[bus.addr];
      n.rreact = q.react[bus.addr];
   end

   // both tables come up cleared
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.rnum   = q.rnum;
   assign bus.rreact = q.rreact;

endmodule

`default_nettype wire
